/* File: hw/ptr_pkg.sv */
// Purpose: Shared constants and carriers for the table-read and data-memory block
// Assumes: One byte-wide data bank, 1K x 14 program memory
// Notes: Program words are 14 bits wide; upper high-byte bits read as zero
package ptr_pkg;

  localparam int PTR_PM_ADDR_W = 10;
  localparam int PTR_PM_WORD_W = 14;
  localparam int PTR_DM_ADDR_W = 8;
  localparam logic [9:0] PTR_RESET_VECTOR = 10'h000;
  localparam logic [1:0] PTR_LAST_PAGE = 2'h3;
  localparam logic [7:0] PTR_SPR_LAST = 8'h5f;
  localparam logic [7:0] PTR_GPR_FIRST = 8'h60;
  localparam logic [7:0] PTR_GPR_LAST = 8'hbf;
  localparam int PTR_GPR_DEPTH = 96;
  localparam logic [7:0] PTR_ADDR_TBLP = 8'h07;
  localparam logic [7:0] PTR_ADDR_THB = 8'h08;
  localparam logic [7:0] PTR_ADDR_TBHP = 8'h09;
  localparam logic [7:0] PTR_ZERO_BYTE = 8'h00;
  localparam int PTR_TABLE_CYCLES = 2;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ptr_dm_req_type;

  typedef struct packed {
    logic start;
    logic last_page;
    logic [7:0] dest;
  } ptr_tab_req_type;

endpackage

/* File: hw/ptr_gpr_ram.sv */
// Purpose: General-purpose byte RAM with registered read data
// Assumes: Index already offset from the area base
// Notes: No reset of contents, as for real RAM
`timescale 1ns/1ps
`default_nettype none
module ptr_gpr_ram
  import ptr_pkg::*;
#(
  parameter int DEPTH = PTR_GPR_DEPTH
)
(
  // Clock
  input wire logic core_clk,
  input wire logic clk_en,
  // Access
  input wire logic wr_en,
  input wire logic [6:0] idx,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);

  initial
  begin
    if (DEPTH < 1 || DEPTH > 128)
      $error("ptr_gpr_ram: DEPTH out of range");
  end

  logic [7:0] mem_q [DEPTH];

  always_ff @(posedge core_clk)
  begin
    if (clk_en && wr_en && int'(idx) < DEPTH)
      mem_q[idx] <= wdata;
  end

  always_ff @(posedge core_clk)
  begin
    if (clk_en)
      rdata <= (int'(idx) < DEPTH) ? mem_q[idx] : PTR_ZERO_BYTE;
  end

endmodule
`default_nettype wire

/* File: hw/ptr_pin_sync.sv */
// Purpose: Two-flop synchroniser for a group of pin inputs
// Assumes: Pins are asynchronous to core_clk
// Notes: First stage is read only by the second
`timescale 1ns/1ps
`default_nettype none
module ptr_pin_sync
#(
  parameter int WIDTH = 4
)
(
  // Clock
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  // Pins
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  initial
  begin
    if (WIDTH < 1)
      $error("ptr_pin_sync: WIDTH out of range");
  end

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      meta_q <= '0;
      sync_out <= '0;
    end
    else if (clk_en)
    begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule
`default_nettype wire

/* File: hw/ptr_table_read.sv */
// Purpose: Program-memory table read path and data-memory map
// Assumes: One clk_en pulse per instruction cycle; program memory read has one cycle latency
// Notes: Programming and debug protocols are outside; only pin takeover and input synchronisation are done here
//
// Functional notes
// - Program counter starts at address zero after reset
// - Outside last-page reads, both table pointers locate the fetched word
// - Low byte goes to operand data register
// - High byte captured into high-byte latch
// - Unimplemented high-byte bits read as zero
// - Last-page read uses page 300H plus low pointer
// - Table instructions take three instruction cycles
// - High-byte latch is read-only to software
// - Addresses 00H-5FH decode to special registers
// - Addresses 60H-BFH are read/write general RAM
// - Data memory is one bank of bytes
// - Programming uses one two-way data pin, external clock
// - Programming mode takes over the two port pins
// - Debug data pin two-way, debug clock input
// - Unimplemented special locations read as zero
`timescale 1ns/1ps
`default_nettype none
module ptr_table_read
  import ptr_pkg::*;
#(
  parameter int PM_ADDR_W = PTR_PM_ADDR_W,
  parameter int PM_WORD_W = PTR_PM_WORD_W
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  // Core program counter
  input wire logic pc_load,
  input wire logic [PM_ADDR_W-1:0] pc_load_value,
  input wire logic pc_step,
  output logic [PM_ADDR_W-1:0] pc_q,
  // Core data-memory access
  input wire ptr_dm_req_type dm_req,
  output logic [7:0] dm_rdata,
  output logic dm_rvalid,
  // Core table instructions
  input wire ptr_tab_req_type tab_req,
  output logic tab_busy,
  output logic tab_done,
  // Program memory read port
  output logic pm_rd_en,
  output logic [PM_ADDR_W-1:0] pm_addr,
  input wire logic [PM_WORD_W-1:0] pm_rdata,
  // Programming and debug pins
  input wire logic prog_mode,
  input wire logic prog_serial_data_pin_in,
  output logic prog_serial_data_pin_out,
  output logic prog_serial_data_pin_oe_n,
  input wire logic prog_serial_clock_pin_in,
  input wire logic debug_data_pin_in,
  output logic debug_data_pin_out,
  output logic debug_data_pin_oe_n,
  input wire logic debug_clock_pin_in,
  input wire logic prog_tx_bit,
  input wire logic prog_tx_drive,
  input wire logic dbg_tx_bit,
  input wire logic dbg_tx_drive,
  output logic prog_rx_bit,
  output logic prog_rx_clk,
  output logic dbg_rx_bit,
  output logic dbg_rx_clk,
  // Normal port function on the shared pins
  input wire logic port_a_bit_zero_out,
  input wire logic port_a_bit_zero_oe_n,
  input wire logic port_a_bit_two_out,
  input wire logic port_a_bit_two_oe_n,
  output logic port_a_bit_zero_out_pin,
  output logic port_a_bit_zero_oe_n_pin,
  output logic port_a_bit_two_out_pin,
  output logic port_a_bit_two_oe_n_pin
);

  initial
  begin
    if (PM_ADDR_W != 10 || PM_WORD_W < 9 || PM_WORD_W > 16)
      $error("ptr_table_read: unsupported program memory shape");
  end

  ////////////////////////////////////////////////////////////////////////
  // Program counter

  always_ff @(posedge core_clk)
  begin
    if (rst)
      pc_q <= PTR_RESET_VECTOR;
    else if (clk_en)
    begin
      if (pc_load)
        pc_q <= pc_load_value;
      else if (pc_step && !tab_busy)
        pc_q <= pc_q + 10'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Table pointers and table sequencer

  typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_STORE} ptr_tab_state_type;

  ptr_tab_state_type state_q;
  logic [7:0] tbl_lo_q;
  logic [7:0] tbl_hi_q;
  logic [7:0] thb_q;
  logic [7:0] dest_q;
  logic last_q;
  logic tab_wr;
  logic [7:0] tab_wbyte;
  logic [7:0] hi_byte;

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      state_q <= ST_IDLE;
      dest_q <= PTR_ZERO_BYTE;
      last_q <= 1'b0;
    end
    else if (clk_en)
    begin
      case (state_q)
        ST_IDLE:
        begin
          if (tab_req.start)
          begin
            state_q <= ST_FETCH;
            dest_q <= tab_req.dest;
            last_q <= tab_req.last_page;
          end
        end
        ST_FETCH: state_q <= ST_STORE;
        ST_STORE: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Core stalls for the two extra cycles the table read needs
  assign tab_busy = (state_q != ST_IDLE) || tab_req.start;
  assign tab_done = (state_q == ST_STORE);

  always_comb
  begin
    pm_rd_en = (state_q == ST_FETCH);
    if (last_q)
      pm_addr = {PTR_LAST_PAGE, tbl_lo_q};
    else
      pm_addr = {tbl_hi_q[1:0], tbl_lo_q};
  end

  // Upper bits of the high byte have no storage cell behind them
  always_comb
  begin
    hi_byte = PTR_ZERO_BYTE;
    hi_byte[PM_WORD_W-9:0] = pm_rdata[PM_WORD_W-1:8];
  end

  assign tab_wr = (state_q == ST_STORE);
  assign tab_wbyte = pm_rdata[7:0];

  always_ff @(posedge core_clk)
  begin
    if (rst)
      thb_q <= PTR_ZERO_BYTE;
    else if (clk_en && tab_wr)
      thb_q <= hi_byte;
  end

  ////////////////////////////////////////////////////////////////////////
  // Data-memory write path, one byte-wide bank

  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic wr_any;
  logic is_gpr_w;

  // Table store wins the port; the core is stalled during it anyway
  always_comb
  begin
    wr_any = tab_wr || dm_req.wr;
    wr_addr = tab_wr ? dest_q : dm_req.addr;
    wr_data = tab_wr ? tab_wbyte : dm_req.wdata;
    is_gpr_w = (wr_addr >= PTR_GPR_FIRST) && (wr_addr <= PTR_GPR_LAST);
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      tbl_lo_q <= PTR_ZERO_BYTE;
      tbl_hi_q <= PTR_ZERO_BYTE;
    end
    else if (clk_en && wr_any)
    begin
      if (wr_addr == PTR_ADDR_TBLP)
        tbl_lo_q <= wr_data;
      if (wr_addr == PTR_ADDR_TBHP)
        tbl_hi_q <= wr_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Data-memory read path

  logic [7:0] ram_rdata;
  logic [6:0] ram_idx;
  logic rd_gpr_q;
  logic [7:0] spr_q;

  assign ram_idx = 7'(wr_any ? (wr_addr - PTR_GPR_FIRST) : (dm_req.addr - PTR_GPR_FIRST));

  ptr_gpr_ram #(
    .DEPTH(PTR_GPR_DEPTH)
  ) u_ram (
    .core_clk(core_clk),
    .clk_en(clk_en),
    .wr_en(wr_any && is_gpr_w),
    .idx(ram_idx),
    .wdata(wr_data),
    .rdata(ram_rdata)
  );

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      rd_gpr_q <= 1'b0;
      spr_q <= PTR_ZERO_BYTE;
      dm_rvalid <= 1'b0;
    end
    else if (clk_en)
    begin
      dm_rvalid <= dm_req.rd && !wr_any;
      rd_gpr_q <= (dm_req.addr >= PTR_GPR_FIRST) && (dm_req.addr <= PTR_GPR_LAST);
      if (dm_req.addr <= PTR_SPR_LAST)
      begin
        case (dm_req.addr)
          PTR_ADDR_TBLP: spr_q <= tbl_lo_q;
          PTR_ADDR_TBHP: spr_q <= tbl_hi_q;
          PTR_ADDR_THB: spr_q <= thb_q;
          default: spr_q <= PTR_ZERO_BYTE;
        endcase
      end
      else
        spr_q <= PTR_ZERO_BYTE;
    end
  end

  // Addresses above the general area read zero as well
  assign dm_rdata = rd_gpr_q ? ram_rdata : spr_q;

  ////////////////////////////////////////////////////////////////////////
  // Programming and debug pins

  logic [3:0] pin_sync;

  ptr_pin_sync #(
    .WIDTH(4)
  ) u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .clk_en(clk_en),
    .async_in({debug_clock_pin_in, debug_data_pin_in,
               prog_serial_clock_pin_in, prog_serial_data_pin_in}),
    .sync_out(pin_sync)
  );

  assign prog_rx_bit = pin_sync[0];
  assign prog_rx_clk = pin_sync[1];
  assign dbg_rx_bit = pin_sync[2];
  assign dbg_rx_clk = pin_sync[3];

  // Clock pin is never driven by the device while programming
  always_comb
  begin
    if (prog_mode)
    begin
      port_a_bit_zero_out_pin = prog_tx_bit;
      port_a_bit_zero_oe_n_pin = !prog_tx_drive;
      port_a_bit_two_out_pin = 1'b0;
      port_a_bit_two_oe_n_pin = 1'b1;
    end
    else
    begin
      port_a_bit_zero_out_pin = port_a_bit_zero_out;
      port_a_bit_zero_oe_n_pin = port_a_bit_zero_oe_n;
      port_a_bit_two_out_pin = port_a_bit_two_out;
      port_a_bit_two_oe_n_pin = port_a_bit_two_oe_n;
    end
  end

  assign prog_serial_data_pin_out = port_a_bit_zero_out_pin;
  assign prog_serial_data_pin_oe_n = port_a_bit_zero_oe_n_pin;
  assign debug_data_pin_out = dbg_tx_bit;
  assign debug_data_pin_oe_n = !dbg_tx_drive;

endmodule
`default_nettype wire

/* File: dv/ptr_pm_model.sv */
// Purpose: Program memory model behind the read port
// Assumes: One cycle read latency
// Notes: Word is a fixed function of the address
`timescale 1ns/1ps
`default_nettype none
module ptr_pm_model
(
  // Clock
  input wire logic core_clk,
  // Read port
  input wire logic pm_rd_en,
  input wire logic [9:0] pm_addr,
  output logic [13:0] pm_rdata
);
  initial pm_rdata = 14'h0000;
  // Off fetch the word toggles, so a late sample shows up
  always @(posedge core_clk)
    if (pm_rd_en)
      pm_rdata <= {pm_addr[9:4], pm_addr[7:0] ^ {pm_addr[9:8], 6'h1a}};
    else
      pm_rdata <= ~pm_rdata;
endmodule
`default_nettype wire

/* File: dv/ptr_table_read_chk.sv */
// Purpose: Port assertions for the table-read block
// Assumes: Pointers change only through core writes
// Notes: Pointers are shadowed here as they are not on the ports
`timescale 1ns/1ps
`default_nettype none
module ptr_table_read_chk
  import ptr_pkg::*;
(
  // Clock
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  // Core side
  input wire logic [9:0] pc_q,
  input wire ptr_dm_req_type dm_req,
  input wire logic [7:0] dm_rdata,
  input wire logic dm_rvalid,
  input wire ptr_tab_req_type tab_req,
  input wire logic tab_busy,
  input wire logic tab_done,
  input wire logic pm_rd_en,
  input wire logic [9:0] pm_addr,
  // Pins
  input wire logic prog_mode,
  input wire logic port_a_bit_zero_out,
  input wire logic port_a_bit_zero_out_pin,
  input wire logic port_a_bit_two_oe_n,
  input wire logic port_a_bit_two_oe_n_pin
);
  logic [7:0] tblp_q;
  logic [7:0] tbhp_q;
  logic go;
  always_ff @(posedge core_clk)
    if (rst)
      tblp_q <= 8'h00;
    else if (clk_en && dm_req.wr && dm_req.addr == PTR_ADDR_TBLP)
      tblp_q <= dm_req.wdata;
  always_ff @(posedge core_clk)
    if (rst)
      tbhp_q <= 8'h00;
    else if (clk_en && dm_req.wr && dm_req.addr == PTR_ADDR_TBHP)
      tbhp_q <= dm_req.wdata;
  // A start seen in fetch or store cycle is ignored, so it is no start
  assign go = clk_en && tab_req.start && !pm_rd_en && !tab_done;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  a_reset_vector: assert property ($fell(rst) |-> pc_q == PTR_RESET_VECTOR)
    else $error("pc not at vector");
  a_table_two_cycles: assert property (go |-> tab_busy ##1 (tab_busy && pm_rd_en)
    ##1 (tab_busy && tab_done) ##1 !tab_done) else $error("table timing");
  a_table_addr_full: assert property (go && !tab_req.last_page
    |=> pm_addr == {tbhp_q[1:0], tblp_q}) else $error("table address");
  a_table_last_page: assert property (go && tab_req.last_page
    |=> pm_addr == {PTR_LAST_PAGE, tblp_q}) else $error("last page address");
  a_read_answered: assert property (clk_en && dm_req.rd && !tab_done |=> dm_rvalid)
    else $error("read unanswered");
  a_answer_caused: assert property (dm_rvalid |-> $past(dm_req.rd))
    else $error("answer without read");
  a_high_bits_zero: assert property (dm_rvalid && $past(dm_req.addr) == PTR_ADDR_THB
    |-> dm_rdata[7:6] == 2'h0) else $error("latch top bits");
  a_unused_zero: assert property (dm_rvalid && $past(dm_req.addr) == 8'h04
    |-> dm_rdata == PTR_ZERO_BYTE) else $error("unused not zero");
  a_port_normal: assert property (!prog_mode |-> port_a_bit_zero_out_pin == port_a_bit_zero_out
    && port_a_bit_two_oe_n_pin == port_a_bit_two_oe_n) else $error("port function");
  a_clock_pin_in: assert property (prog_mode |-> port_a_bit_two_oe_n_pin)
    else $error("clock pin driven");
  c_last_page: cover property (go && tab_req.last_page);
  c_read: cover property (dm_rvalid);
  c_prog: cover property (prog_mode);
endmodule
bind ptr_table_read ptr_table_read_chk u_chk (.core_clk(core_clk), .rst(rst), .clk_en(clk_en),
  .pc_q(pc_q), .dm_req(dm_req), .dm_rdata(dm_rdata), .dm_rvalid(dm_rvalid),
  .tab_req(tab_req), .tab_busy(tab_busy), .tab_done(tab_done), .pm_rd_en(pm_rd_en),
  .pm_addr(pm_addr), .prog_mode(prog_mode), .port_a_bit_zero_out(port_a_bit_zero_out),
  .port_a_bit_zero_out_pin(port_a_bit_zero_out_pin), .port_a_bit_two_oe_n(port_a_bit_two_oe_n),
  .port_a_bit_two_oe_n_pin(port_a_bit_two_oe_n_pin));
`default_nettype wire

/* File: dv/test_ptr_table_read.sv */
// Purpose: Self-checking bench for the table-read block
// Assumes: clk_en high except in the program counter scenario
// Notes: Program counter stepped, frozen, loaded and reset mid-run
`timescale 1ns/1ps
`default_nettype none
module test_ptr_table_read
  import ptr_pkg::*;
;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic clk_en = 1'b1;
  logic pc_load = 1'b0;
  logic pc_step = 1'b0;
  logic [9:0] pc_val = 10'h000;
  ptr_dm_req_type dm_req = '0;
  ptr_tab_req_type tab_req = '0;
  logic prog_mode = 1'b0;
  logic [3:0] tx = 4'h0;
  logic [3:0] port = 4'h0;
  logic pdat = 1'b0;
  logic pclk = 1'b0;
  logic ddat = 1'b0;
  logic [9:0] pc_q, pm_addr;
  logic [7:0] dm_rdata;
  logic [13:0] pm_rdata;
  logic dm_rvalid, tab_busy, tab_done, pm_rd_en;
  logic p_out, p_oe_n, d_out, d_oe_n, prx, prxc, drx, drxc;
  logic [3:0] pin_q;
  logic pdat_w, ddat_w;
  int errors = 0;
  int check_count = 0;
  // Wire level: the device wins while it drives
  assign pdat_w = p_oe_n ? pdat : p_out;
  assign ddat_w = d_oe_n ? ddat : d_out;
  initial forever #12.5 core_clk = ~core_clk;
  ptr_pm_model u_pm (.core_clk(core_clk), .pm_rd_en(pm_rd_en), .pm_addr(pm_addr),
    .pm_rdata(pm_rdata));
  ptr_table_read dut (.core_clk(core_clk), .rst(rst), .clk_en(clk_en), .pc_load(pc_load),
    .pc_load_value(pc_val), .pc_step(pc_step), .pc_q(pc_q), .dm_req(dm_req),
    .dm_rdata(dm_rdata), .dm_rvalid(dm_rvalid), .tab_req(tab_req), .tab_busy(tab_busy),
    .tab_done(tab_done), .pm_rd_en(pm_rd_en), .pm_addr(pm_addr), .pm_rdata(pm_rdata),
    .prog_mode(prog_mode), .prog_serial_data_pin_in(pdat_w), .prog_serial_data_pin_out(p_out),
    .prog_serial_data_pin_oe_n(p_oe_n), .prog_serial_clock_pin_in(pclk),
    .debug_data_pin_in(ddat_w), .debug_data_pin_out(d_out), .debug_data_pin_oe_n(d_oe_n),
    .debug_clock_pin_in(pclk), .prog_tx_bit(tx[3]), .prog_tx_drive(tx[2]),
    .dbg_tx_bit(tx[1]), .dbg_tx_drive(tx[0]), .prog_rx_bit(prx), .prog_rx_clk(prxc),
    .dbg_rx_bit(drx), .dbg_rx_clk(drxc), .port_a_bit_zero_out(port[3]),
    .port_a_bit_zero_oe_n(port[2]), .port_a_bit_two_out(port[1]),
    .port_a_bit_two_oe_n(port[0]), .port_a_bit_zero_out_pin(pin_q[3]),
    .port_a_bit_zero_oe_n_pin(pin_q[2]), .port_a_bit_two_out_pin(pin_q[1]),
    .port_a_bit_two_oe_n_pin(pin_q[0]));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    if (errors == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] %0t saw %h want %h", $time, seen, exp);
    end
  endtask
  function automatic logic [13:0] pm_word(input logic [9:0] a);
    return {a[9:4], a[7:0] ^ {a[9:8], 6'h1a}};
  endfunction
  task automatic dm_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    dm_req = '{1'b1, 1'b0, a, d};
    @(negedge core_clk);
    dm_req = '0;
  endtask
  task automatic dm_rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge core_clk);
    dm_req = '{1'b0, 1'b1, a, 8'h00};
    @(negedge core_clk);
    dm_req = '0;
    check(dm_rvalid, 1'b1);
    d = dm_rdata;
  endtask
  // Waits for the store cycle under a bound, then one more cycle
  task automatic tab(input logic last, input logic [7:0] dest);
    @(negedge core_clk);
    tab_req = '{1'b1, last, dest};
    @(negedge core_clk);
    tab_req = '0;
    for (int i = 0; i < 8 && tab_done !== 1'b1; i++)
      @(negedge core_clk);
    if (tab_done !== 1'b1)
    begin
      errors++;
      end_of_test();
    end
    @(negedge core_clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_ram();
    logic [7:0] d;
    dm_wr(PTR_GPR_FIRST, 8'ha5);
    dm_wr(PTR_GPR_LAST, 8'h3c);
    dm_wr(8'h04, 8'hff);
    dm_rd(PTR_GPR_FIRST, d);
    check(d, 8'ha5);
    dm_rd(PTR_GPR_LAST, d);
    check(d, 8'h3c);
    dm_rd(8'h04, d);
    check(d, PTR_ZERO_BYTE);
  endtask
  task automatic t_table();
    logic [7:0] d;
    logic [13:0] w;
    dm_wr(PTR_ADDR_TBLP, 8'h06);
    dm_wr(PTR_ADDR_TBHP, 8'h02);
    tab(1'b0, 8'h61);
    w = pm_word(10'h206);
    dm_rd(8'h61, d);
    check(d, w[7:0]);
    dm_rd(PTR_ADDR_THB, d);
    check(d, {2'h0, w[13:8]});
    dm_rd(PTR_ADDR_TBLP, d);
    check(d, 8'h06);
    dm_wr(PTR_ADDR_TBHP, 8'h01);
    tab(1'b1, 8'h62);
    w = pm_word(10'h306);
    dm_rd(8'h62, d);
    check(d, w[7:0]);
    dm_wr(PTR_ADDR_THB, 8'hff);
    dm_rd(PTR_ADDR_THB, d);
    check(d, {2'h0, w[13:8]});
  endtask
  task automatic t_pins();
    @(negedge core_clk);
    port = 4'ha;
    @(negedge core_clk);
    check(pin_q, 4'ha);
    prog_mode = 1'b1;
    tx = 4'hc;
    pclk = 1'b1;
    ddat = 1'b1;
    repeat (3) @(negedge core_clk);
    check({p_oe_n, p_out, prx, prxc}, 4'h7);
    check({d_oe_n, drx, drxc, pin_q[0]}, 4'hf);
    tx = 4'h1;
    repeat (3) @(negedge core_clk);
    check({p_oe_n, prx, d_oe_n, drx}, 4'h8);
    prog_mode = 1'b0;
  endtask
  // Steps, freezes on clk_en low, loads, then a mid-run reset
  task automatic t_pc();
    logic [7:0] d;
    @(negedge core_clk);
    pc_step = 1'b1;
    repeat (3) @(negedge core_clk);
    check(pc_q, 10'h003);
    clk_en = 1'b0;
    @(negedge core_clk);
    check(pc_q, 10'h003);
    clk_en = 1'b1;
    pc_step = 1'b0;
    pc_load = 1'b1;
    pc_val = 10'h2a5;
    @(negedge core_clk);
    check(pc_q, 10'h2a5);
    pc_load = 1'b0;
    rst = 1'b1;
    repeat (2) @(negedge core_clk);
    rst = 1'b0;
    @(negedge core_clk);
    check(pc_q, PTR_RESET_VECTOR);
    dm_rd(PTR_ADDR_THB, d);
    check(d, PTR_ZERO_BYTE);
  endtask
  initial
  begin
    repeat (6) @(negedge core_clk);
    rst = 1'b0;
    @(negedge core_clk);
    check(pc_q, PTR_RESET_VECTOR);
    t_ram();
    t_table();
    t_pc();
    t_pins();
    end_of_test();
  end
endmodule
`default_nettype wire
